// ---- hw/adcc_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the converter
// Overview of operation
// - Six-bit input select in control 0 bits 7-2; gap codes reserved
// - Top select codes pick fixed ref 2, fixed ref 1, DAC, temp, ground
// - Status bit written as one together with enable bit starts a conversion; reads one until done
// - Hardware clears the status bit when the conversion finishes
// - Enable bit 0 powers the converter; clear means off, no current
// - Format one: right justify, high register bits 7-2 forced zero
// - Format zero: left justify, low register lower six bits forced zero
// - Clock field: system clock /2,/8,/32,/4,/16,/64 or RC oscillator
// - Reference field: 00 supply, 10 external pin, 11 fixed; 01 reserved
// - Trigger register: 4-bit source in bits 3-0; upper bits read zero
// - Every trigger source counts only on a rising edge, never a level
// - Left format: high holds result 9-2, low bits 7-6 hold result 1-0
// - Right format: high register bits 1-0 hold result bits 9-8
// - Control fields reset to zero; result registers keep contents
// - Right format: low register holds result bits 7-0
// - Rising edge of selected trigger sets the status bit, not in sleep
// - Trigger code 0 off, 1 mapped pin, higher codes peripheral outputs
// - Sleep without RC clock aborts and powers off; enable bit kept
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
`define ADCC_OFS_CTRL0     8'h00
`define ADCC_OFS_CTRL1     8'h04
`define ADCC_OFS_TRIG      8'h08
`define ADCC_OFS_RES_HI    8'h0c
`define ADCC_OFS_RES_LO    8'h10
`define ADCC_RST_CTRL0     8'h00
`define ADCC_RST_CTRL1     8'h00
`define ADCC_RST_TRIG      4'h0
`define ADCC_ON_BIT        0
`define ADCC_GO_BIT        1
`define ADCC_CHS_LSB       2
`define ADCC_FMT_BIT       7
`define ADCC_CS_LSB        4
`define ADCC_PREF_LSB      0
`define ADCC_CHS_GND       6'h3b
`define ADCC_CHS_TEMP      6'h3c
`define ADCC_CHS_DAC       6'h3d
`define ADCC_CHS_FVR1      6'h3e
`define ADCC_CHS_FVR2      6'h3f
`define ADCC_CHS_PORTA_TOP 6'h05
`define ADCC_CHS_PORTB_LO  6'h0c
`define ADCC_CHS_PORTC_TOP 6'h17
`define ADCC_TRIG_OFF      4'h0
`define ADCC_TRIG_PIN      4'h1
`define ADCC_DIV2_LIM      6'h01
`define ADCC_DIV4_LIM      6'h03
`define ADCC_DIV8_LIM      6'h07
`define ADCC_DIV16_LIM     6'h0f
`define ADCC_DIV32_LIM     6'h1f
`define ADCC_DIV64_LIM     6'h3f
`endif

// ---- hw/adcc_pkg.sv ----
// Types shared by the converter control logic
package adcc_pkg;
   typedef enum logic [2:0] {
      ADCC_SRC_PIN, ADCC_SRC_FVR2, ADCC_SRC_FVR1, ADCC_SRC_DAC,
      ADCC_SRC_TEMP, ADCC_SRC_GND, ADCC_SRC_RSVD
   } adcc_src_type;
   typedef enum logic [1:0] {
      ADCC_REF_SUPPLY, ADCC_REF_PIN, ADCC_REF_FIXED, ADCC_REF_RSVD
   } adcc_ref_type;
   // Everything the analog core needs from the control logic
   typedef struct packed {
      logic         power;
      logic         start;
      logic         clk_tick;
      logic [5:0]   input_select;
      adcc_src_type source;
      adcc_ref_type reference;
   } adcc_core_req_type;
   // Completion report from the analog core
   typedef struct packed {
      logic       done;
      logic [9:0] conversion_result;
   } adcc_core_rsp_type;
endpackage : adcc_pkg

// ---- hw/adcc_clkdiv.sv ----
// Conversion clock tick generator
`timescale 1ns/100ps
`include "adcc_cfg.svh"
module adcc_clkdiv
   import adcc_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Selection and oscillator level
   input  wire logic [2:0] conversion_clock_select,
   input  wire logic       rc_level,
   // Tick towards the core and RC mode flag
   output logic            tick,
   output logic            rc_mode
);
   logic [5:0] cnt_reg;
   logic [5:0] lim;
   logic       rc_prev_reg;

   // Divider limit per code; 011 and 111 fall to the RC path
   always_comb begin
      unique case (conversion_clock_select)
         3'h0:    lim = `ADCC_DIV2_LIM;
         3'h1:    lim = `ADCC_DIV8_LIM;
         3'h2:    lim = `ADCC_DIV32_LIM;
         3'h4:    lim = `ADCC_DIV4_LIM;
         3'h5:    lim = `ADCC_DIV16_LIM;
         3'h6:    lim = `ADCC_DIV64_LIM;
         default: lim = `ADCC_DIV2_LIM;
      endcase
   end

   // Codes 011 and 111 pick the dedicated RC oscillator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_mode <= 1'b0;
      end else begin
         rc_mode <= (conversion_clock_select[1:0] == 2'h3);
      end
   end

   // Counter restarts at the limit; a tick each wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg     <= 6'h00;
         rc_prev_reg <= 1'b0;
         tick        <= 1'b0;
      end else begin
         rc_prev_reg <= rc_level;
         if (rc_mode) begin
            cnt_reg <= 6'h00;
            tick    <= rc_level & ~rc_prev_reg;
         end else if (cnt_reg >= lim) begin
            cnt_reg <= 6'h00;
            tick    <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 6'h01;
            tick    <= 1'b0;
         end
      end
   end
endmodule : adcc_clkdiv

// ---- hw/adcc_top.sv ----
// Converter control, result registers and APB slave
`timescale 1ns/100ps
`include "adcc_cfg.svh"
module adcc_top
   import adcc_pkg::*;
(
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Analog core
   output adcc_core_req_type core_req,
   input  adcc_core_rsp_type core_rsp,
   // Pins from outside the clock domain
   input  wire logic        sleep_pin,
   input  wire logic        rc_osc_pin,
   input  wire logic        trigger_pin,
   // Peripheral trigger sources, codes 2 to 15
   input  wire logic [15:2] trigger_sources,
   // Completion event
   output logic             conversion_done_evt
);
   // Control registers
   logic [5:0]  input_select_reg;
   logic        busy_reg;
   logic        converter_enable_reg;
   logic        result_format_reg;
   logic [2:0]  conversion_clock_select_reg;
   logic [1:0]  positive_reference_select_reg;
   logic [3:0]  trigger_source_select_reg;
   logic [7:0]  result_high_reg;
   logic [7:0]  result_low_reg;
   // Core request flops
   logic        power_reg;
   logic        start_reg;
   adcc_src_type source_reg;
   adcc_ref_type reference_reg;
   // Pin filtering: three stages, agreed level
   logic [2:0]  sync1_reg;
   logic [2:0]  sync2_reg;
   logic [2:0]  sync3_reg;
   logic [2:0]  pin_level_reg;
   logic        sleep_lvl;
   logic        rc_lvl;
   logic        trig_pin_lvl;
   // Trigger edge detection
   logic [15:0] trig_vec;
   logic        trig_cur;
   logic        trig_prev_reg;
   logic        trig_edge;
   // Bus decode
   logic        setup_ph;
   logic        wr_en;
   logic        mapped;
   logic [7:0]  rd_byte;
   logic        wr_ctrl0;
   logic        wr_ctrl1;
   logic        wr_trig;
   logic        wr_hi;
   logic        wr_lo;
   // Conversion control
   logic        clk_tick;
   logic        rc_mode;
   logic        sleep_abort;
   logic        set_sw;
   logic        set_trig;
   logic        set_any;
   logic        load;
   logic        clr_any;

   // Pins cross in with three flops; level moves when stages 2 and 3 agree
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_reg[gi]     <= 1'b0;
               sync2_reg[gi]     <= 1'b0;
               sync3_reg[gi]     <= 1'b0;
               pin_level_reg[gi] <= 1'b0;
            end else begin
               sync1_reg[gi] <= (gi == 0) ? sleep_pin :
                                (gi == 1) ? rc_osc_pin : trigger_pin;
               sync2_reg[gi] <= sync1_reg[gi];
               sync3_reg[gi] <= sync2_reg[gi];
               if (sync2_reg[gi] == sync3_reg[gi]) begin
                  pin_level_reg[gi] <= sync3_reg[gi];
               end
            end
         end
      end
   endgenerate
   assign sleep_lvl    = pin_level_reg[0];
   assign rc_lvl       = pin_level_reg[1];
   assign trig_pin_lvl = pin_level_reg[2];

   // Conversion clock tick from divider or RC oscillator
   adcc_clkdiv u_clkdiv (
      .pclk                    (pclk),
      .presetn                 (presetn),
      .conversion_clock_select (conversion_clock_select_reg),
      .rc_level                (rc_lvl),
      .tick                    (clk_tick),
      .rc_mode                 (rc_mode)
   );

   // APB decode; one access phase cycle, no wait states
   assign setup_ph = psel & ~penable;
   assign wr_en    = psel & penable & pready & pwrite & ~pslverr;
   assign wr_ctrl0 = wr_en & (paddr == `ADCC_OFS_CTRL0);
   assign wr_ctrl1 = wr_en & (paddr == `ADCC_OFS_CTRL1);
   assign wr_trig  = wr_en & (paddr == `ADCC_OFS_TRIG);
   assign wr_hi    = wr_en & (paddr == `ADCC_OFS_RES_HI);
   assign wr_lo    = wr_en & (paddr == `ADCC_OFS_RES_LO);

   // Read mux; unimplemented bits return zero
   always_comb begin
      mapped  = 1'b1;
      rd_byte = 8'h00;
      unique case (paddr)
         `ADCC_OFS_CTRL0:
            rd_byte = {input_select_reg, busy_reg, converter_enable_reg};
         `ADCC_OFS_CTRL1:
            rd_byte = {result_format_reg, conversion_clock_select_reg,
                       2'h0, positive_reference_select_reg};
         `ADCC_OFS_TRIG:
            rd_byte = {4'h0, trigger_source_select_reg};
         `ADCC_OFS_RES_HI: rd_byte = result_high_reg;
         `ADCC_OFS_RES_LO: rd_byte = result_low_reg;
         default:          mapped  = 1'b0;
      endcase
   end

   // Answer registered in setup, so pready rises with the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup_ph;
         pslverr <= setup_ph & ~mapped;
         if (setup_ph) begin
            prdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   // Control fields; all clear on any reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_select_reg              <= 6'(`ADCC_RST_CTRL0 >> 2);
         converter_enable_reg          <= 1'b0;
         result_format_reg             <= 1'b0;
         conversion_clock_select_reg   <= 3'h0;
         positive_reference_select_reg <= 2'h0;
         trigger_source_select_reg     <= `ADCC_RST_TRIG;
      end else begin
         if (wr_ctrl0) begin
            input_select_reg     <= pwdata[7:`ADCC_CHS_LSB];
            converter_enable_reg <= pwdata[`ADCC_ON_BIT];
         end
         if (wr_ctrl1) begin
            result_format_reg             <= pwdata[`ADCC_FMT_BIT];
            conversion_clock_select_reg   <= pwdata[6:`ADCC_CS_LSB];
            positive_reference_select_reg <= pwdata[1:`ADCC_PREF_LSB];
         end
         if (wr_trig) begin
            trigger_source_select_reg <= pwdata[3:0];
         end
      end
   end

   // Trigger sources; code zero has no source and never fires
   assign trig_vec = {trigger_sources, trig_pin_lvl, 1'b0};
   assign trig_cur = trig_vec[trigger_source_select_reg];

   // Only a low to high step counts; a held level starts nothing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_prev_reg <= 1'b0;
      end else begin
         trig_prev_reg <= trig_cur;
      end
   end
   assign trig_edge = trig_cur & ~trig_prev_reg &
                      (trigger_source_select_reg != `ADCC_TRIG_OFF);

   // Start and stop terms of the status bit
   assign sleep_abort = sleep_lvl & ~rc_mode;
   assign set_sw   = wr_ctrl0 & pwdata[`ADCC_GO_BIT] &
                     pwdata[`ADCC_ON_BIT];
   assign set_trig = trig_edge & converter_enable_reg & ~sleep_lvl;
   assign set_any  = (set_sw | set_trig) & ~sleep_abort;
   assign load     = busy_reg & core_rsp.done & ~sleep_abort;
   assign clr_any  = load | sleep_abort | ~converter_enable_reg;

   // Status bit: a start in the same cycle as a finish wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg  <= 1'b0;
         start_reg <= 1'b0;
      end else begin
         if (set_any) begin
            busy_reg <= 1'b1;
         end else if (clr_any) begin
            busy_reg <= 1'b0;
         end
         start_reg <= set_any & (~busy_reg | clr_any);
      end
   end

   // Completion event in the cycle the status bit drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_done_evt <= 1'b0;
      end else begin
         conversion_done_evt <= load;
      end
   end

   // Results hold across resets; both halves load together
   always_ff @(posedge pclk) begin
      if (load) begin
         if (result_format_reg) begin
            result_high_reg <= {6'h00,
               core_rsp.conversion_result[9:8]};
            result_low_reg  <= core_rsp.conversion_result[7:0];
         end else begin
            result_high_reg <= core_rsp.conversion_result[9:2];
            result_low_reg  <= {core_rsp.conversion_result[1:0],
                                6'h00};
         end
      end else begin
         if (wr_hi) begin
            result_high_reg <= pwdata[7:0];
         end
         if (wr_lo) begin
            result_low_reg <= pwdata[7:0];
         end
      end
   end

   // Power follows the enable bit's next value, so a start written together
   // with the enable never reaches a core that is still off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_reg <= 1'b0;
      end else begin
         power_reg <= (wr_ctrl0 ? pwdata[`ADCC_ON_BIT] : converter_enable_reg)
                      & ~sleep_abort;
      end
   end

   // Input source decode for the analog multiplexer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_reg <= ADCC_SRC_PIN;
      end else begin
         if (input_select_reg == `ADCC_CHS_FVR2) begin
            source_reg <= ADCC_SRC_FVR2;
         end else if (input_select_reg == `ADCC_CHS_FVR1) begin
            source_reg <= ADCC_SRC_FVR1;
         end else if (input_select_reg == `ADCC_CHS_DAC) begin
            source_reg <= ADCC_SRC_DAC;
         end else if (input_select_reg == `ADCC_CHS_TEMP) begin
            source_reg <= ADCC_SRC_TEMP;
         end else if (input_select_reg == `ADCC_CHS_GND) begin
            source_reg <= ADCC_SRC_GND;
         end else if (input_select_reg <= `ADCC_CHS_PORTA_TOP ||
                      (input_select_reg >= `ADCC_CHS_PORTB_LO &&
                       input_select_reg <= `ADCC_CHS_PORTC_TOP)) begin
            source_reg <= ADCC_SRC_PIN;
         end else begin
            source_reg <= ADCC_SRC_RSVD;
         end
      end
   end

   // Reference decode; code 01 flagged, core keeps the supply then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reference_reg <= ADCC_REF_SUPPLY;
      end else begin
         unique case (positive_reference_select_reg)
            2'h0: reference_reg <= ADCC_REF_SUPPLY;
            2'h1: reference_reg <= ADCC_REF_RSVD;
            2'h2: reference_reg <= ADCC_REF_PIN;
            2'h3: reference_reg <= ADCC_REF_FIXED;
         endcase
      end
   end

   // Core request bundle, every field a flop
   assign core_req.power        = power_reg;
   assign core_req.start        = start_reg;
   assign core_req.clk_tick     = clk_tick;
   assign core_req.input_select = input_select_reg;
   assign core_req.source       = source_reg;
   assign core_req.reference    = reference_reg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_SW_START: assert property (
      set_sw && !sleep_abort |=> busy_reg &&
      start_reg == (!$past(busy_reg) || $past(clr_any)))
      else $error("software start did not raise status");
   AST_DONE_CLEARS: assert property (
      load && !set_any |=> !busy_reg)
      else $error("status bit not cleared on completion");
   AST_RIGHT_FMT: assert property (
      load && result_format_reg |=> result_high_reg[7:2] == 6'h00 &&
      result_high_reg[1:0] == $past(core_rsp.conversion_result[9:8]) &&
      result_low_reg == $past(core_rsp.conversion_result[7:0]))
      else $error("right justified result wrong");
   AST_LEFT_FMT: assert property (
      load && !result_format_reg |=> result_low_reg[5:0] == 6'h00 &&
      result_high_reg == $past(core_rsp.conversion_result[9:2]))
      else $error("left justified result wrong");
   AST_DONE_EVT: assert property (
      load |=> conversion_done_evt && (!busy_reg || $past(set_any)))
      else $error("completion event missing");
   AST_TRIG_START: assert property (
      set_trig && !sleep_abort |=> busy_reg)
      else $error("trigger edge did not start conversion");
   AST_TRIG_LEVEL: assert property (
      trig_prev_reg && trig_cur && !set_sw |=> $stable(busy_reg) ||
      !busy_reg)
      else $error("held trigger level started conversion");
   AST_TRIG_UPPER: assert property (
      setup_ph && paddr == `ADCC_OFS_TRIG |=> prdata[31:4] == 28'h0)
      else $error("trigger register upper bits not zero");
   AST_SLEEP_OFF: assert property (
      sleep_abort |=> !power_reg && !busy_reg)
      else $error("sleep did not power down converter");
   AST_NO_POWER: assert property (
      !converter_enable_reg |-> !power_reg)
      else $error("converter powered while disabled");

   COV_SW_CONV: cover property (set_sw ##[1:200] load);
   COV_TRIG_CONV: cover property (set_trig ##[1:200] load);
   COV_SLEEP_ABORT: cover property (busy_reg && sleep_abort);
   COV_BACK_TO_BACK: cover property (load && set_any);
endmodule : adcc_top

// ---- tb/adcc_core_model.sv ----
// Behavioural analog core: converts after a short or long delay
`timescale 1ns/100ps
module adcc_core_model
   import adcc_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Control side
   input  adcc_core_req_type core_req,
   input  wire logic        slow,
   input  wire logic [9:0]  value,
   output adcc_core_rsp_type core_rsp
);
   logic       busy_reg;
   logic [5:0] cnt_reg;
   logic [9:0] last_reg;
   // Conversion timer; losing power drops the running cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg <= 1'b0;
         cnt_reg  <= 6'h00;
      end else if (!core_req.power) begin
         busy_reg <= 1'b0;
      end else if (core_req.start) begin
         busy_reg <= 1'b1;
         cnt_reg  <= slow ? 6'h28 : 6'h03;
      end else if (busy_reg) begin
         cnt_reg  <= cnt_reg - 6'h01;
         busy_reg <= (cnt_reg != 6'h01);
      end
   end
   // Remember last result so stale data can be shown inverted
   always_ff @(posedge pclk) begin
      if (core_rsp.done) begin
         last_reg <= value;
      end
   end
   assign core_rsp.done = busy_reg && (cnt_reg == 6'h01);
   // Result only meaningful with done; never leave the old value up
   assign core_rsp.conversion_result = core_rsp.done ? value : ~last_reg;
endmodule : adcc_core_model

// ---- tb/tb.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`include "adcc_cfg.svh"
module tb
   import adcc_pkg::*;
;
   logic              pclk = 1'b0, presetn = 1'b0;
   logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0, prdata, q;
   logic              pready, pslverr, err, evt, slow = 1'b1;
   logic              sleep_pin = 1'b0, rc_osc_pin = 1'b0;
   logic              trigger_pin = 1'b0;
   logic [15:2]       trigger_sources = 14'h0;
   logic [9:0]        value = 10'h0;
   logic [3:0]        rc_cnt = 4'h0;
   adcc_core_req_type core_req;
   adcc_core_rsp_type core_rsp;
   int                n_fail = 0, n_checks = 0, n_evt = 0, n_tick = 0;

   always #10 pclk = ~pclk;
   // Slow free-running oscillator pin
   always @(posedge pclk) begin
      rc_cnt     <= rc_cnt + 4'h1;
      rc_osc_pin <= rc_cnt[3];
   end
   // Pulse counters on the falling edge, clear of launch races
   always @(negedge pclk) begin
      if (evt === 1'b1) n_evt++;
      if (core_req.clk_tick === 1'b1) n_tick++;
   end

   adcc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_req(core_req), .core_rsp(core_rsp), .sleep_pin(sleep_pin),
      .rc_osc_pin(rc_osc_pin), .trigger_pin(trigger_pin),
      .trigger_sources(trigger_sources), .conversion_done_evt(evt));
   adcc_core_model core_u (.pclk(pclk), .presetn(presetn),
      .core_req(core_req), .slow(slow), .value(value),
      .core_rsp(core_rsp));

   task automatic summarize;
      if (n_fail == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   task automatic check(input string nm, input logic [31:0] s,
                        input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : check

   task automatic cycles(input int n);
      repeat (n) @(posedge pclk);
   endtask : cycles

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1) begin
         n_fail++;
         summarize();
      end
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Poll the status bit until the conversion is over
   task automatic wait_idle;
      int i;
      i = 0;
      do begin
         apb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
         i++;
      end while (q[1] !== 1'b0 && i < 60);
      if (q[1] !== 1'b0) begin
         n_fail++;
         summarize();
      end
   endtask : wait_idle

   task automatic t_reset;
      apb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
      check("ctrl0 reset", q, 32'h0);
      apb(1'b0, `ADCC_OFS_CTRL1, 32'h0);
      check("ctrl1 reset", q, 32'h0);
      apb(1'b0, `ADCC_OFS_TRIG, 32'h0);
      check("trig reset", q, 32'h0);
      apb(1'b1, 8'h14, 32'hff);
      check("unmapped wr err", err, 32'h1);
      apb(1'b0, 8'h14, 32'h0);
      check("unmapped rd err", err, 32'h1);
      check("unmapped rd", q, 32'h0);
      apb(1'b1, `ADCC_OFS_CTRL1, 32'hff);
      apb(1'b0, `ADCC_OFS_CTRL1, 32'h0);
      check("ctrl1 fields", q, 32'hf3);
      apb(1'b1, `ADCC_OFS_TRIG, 32'hff);
      apb(1'b0, `ADCC_OFS_TRIG, 32'h0);
      check("trig fields", q, 32'h0f);
      apb(1'b1, `ADCC_OFS_TRIG, 32'h0);
   endtask : t_reset

   task automatic t_decode;
      logic [5:0]   sc[8] = '{6'h3f, 6'h3e, 6'h3d, 6'h3c, 6'h3b,
                              6'h00, 6'h17, 6'h08};
      adcc_src_type se[8] = '{ADCC_SRC_FVR2, ADCC_SRC_FVR1, ADCC_SRC_DAC,
                              ADCC_SRC_TEMP, ADCC_SRC_GND, ADCC_SRC_PIN,
                              ADCC_SRC_PIN, ADCC_SRC_RSVD};
      adcc_ref_type re[4] = '{ADCC_REF_SUPPLY, ADCC_REF_RSVD,
                              ADCC_REF_PIN, ADCC_REF_FIXED};
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `ADCC_OFS_CTRL0, {24'h0, sc[i], 2'b00});
         cycles(2);
         check("source", core_req.source, se[i]);
         check("select", core_req.input_select, sc[i]);
      end
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `ADCC_OFS_CTRL1, i);
         cycles(2);
         check("reference", core_req.reference, re[i]);
      end
      // Start without enable is ignored and keeps the core off
      apb(1'b1, `ADCC_OFS_CTRL0, 32'h02);
      apb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
      check("no start off", q, 32'h0);
      check("power off", core_req.power, 32'h0);
      apb(1'b1, `ADCC_OFS_CTRL0, 32'h01);
      cycles(2);
      check("power on", core_req.power, 32'h1);
   endtask : t_decode

   task automatic t_conv(input logic fmt, input logic [9:0] r,
                         input logic sl);
      logic [31:0] eh, el;
      slow  <= sl;
      value <= r;
      n_evt = 0;
      apb(1'b1, `ADCC_OFS_CTRL1, {24'h0, fmt, 7'h00});
      apb(1'b1, `ADCC_OFS_CTRL0, 32'h0f);
      if (sl) begin
         apb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
         check("busy", q, 32'h0f);
      end
      wait_idle();
      check("idle", q, 32'h0d);
      check("done event", n_evt, 32'h1);
      eh = fmt ? {30'h0, r[9:8]} : {24'h0, r[9:2]};
      el = fmt ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h0};
      apb(1'b0, `ADCC_OFS_RES_HI, 32'h0);
      check("res hi", q, eh);
      apb(1'b0, `ADCC_OFS_RES_LO, 32'h0);
      check("res lo", q, el);
   endtask : t_conv

   // Second reset: control clears, results survive
   task automatic t_rst(input logic [9:0] r);
      presetn <= 1'b0;
      cycles(2);
      presetn <= 1'b1;
      apb(1'b0, `ADCC_OFS_CTRL1, 32'h0);
      check("ctrl1 rereset", q, 32'h0);
      apb(1'b0, `ADCC_OFS_RES_HI, 32'h0);
      check("res kept", q, {24'h0, r[9:2]});
   endtask : t_rst

   task automatic t_trig;
      slow <= 1'b1;
      apb(1'b1, `ADCC_OFS_TRIG, 32'h01);
      apb(1'b1, `ADCC_OFS_CTRL0, 32'h01);
      trigger_pin <= 1'b1;
      cycles(8);
      apb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
      check("pin trigger", q, 32'h03);
      wait_idle();
      cycles(10);
      apb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
      check("level no trigger", q, 32'h01);
      trigger_pin <= 1'b0;
      apb(1'b1, `ADCC_OFS_TRIG, 32'h02);
      trigger_sources[2] <= 1'b1;
      cycles(2);
      apb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
      check("source trigger", q, 32'h03);
      wait_idle();
      trigger_sources[2] <= 1'b0;
      apb(1'b1, `ADCC_OFS_TRIG, 32'h00);
      trigger_pin <= 1'b1;
      cycles(8);
      apb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
      check("trigger disabled", q, 32'h01);
      trigger_pin <= 1'b0;
      // Sleep with divider clock aborts, enable stays set
      apb(1'b1, `ADCC_OFS_CTRL0, 32'h03);
      sleep_pin <= 1'b1;
      cycles(8);
      apb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
      check("sleep abort", q, 32'h01);
      check("sleep power", core_req.power, 32'h0);
      sleep_pin <= 1'b0;
      cycles(6);
      // RC conversion clock keeps the conversion alive through sleep
      apb(1'b1, `ADCC_OFS_CTRL1, 32'h30);
      apb(1'b1, `ADCC_OFS_CTRL0, 32'h03);
      sleep_pin <= 1'b1;
      cycles(8);
      apb(1'b0, `ADCC_OFS_CTRL0, 32'h0);
      check("rc sleep busy", q, 32'h03);
      check("rc sleep power", core_req.power, 32'h1);
      sleep_pin <= 1'b0;
      wait_idle();
   endtask : t_trig

   // Tick rate per clock code; RC codes follow the 16-cycle oscillator pin
   task automatic t_clk;
      int dv[8] = '{2, 8, 32, 16, 4, 16, 64, 16};
      int t0;
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `ADCC_OFS_CTRL1, i << 4);
         cycles(4);
         t0 = n_tick;
         cycles(128);
         t0 = n_tick - t0 - 128 / dv[i];
         check("tick rate", t0 >= -1 && t0 <= 1, 32'h1);
      end
   endtask : t_clk

   initial begin
      cycles(6);
      presetn <= 1'b1;
      t_reset();
      t_decode();
      t_conv(1'b1, 10'h2a5, 1'b1);
      t_conv(1'b0, 10'h15a, 1'b0);
      t_rst(10'h15a);
      t_trig();
      t_clk();
      summarize();
   end
endmodule : tb
